/* File: logic/prmd_defs.svh */
// constants of the rate-multiplier pulse dac: offsets, fields, reset values, counts
`ifndef PRMD_DEFS_SVH
`define PRMD_DEFS_SVH
// -----------------------------------------------------------------
// counter and field widths
// -----------------------------------------------------------------
`define PRMD_CNT_W       10
`define PRMD_PW_W        6
`define PRMD_FS_W        4
`define PRMD_IDX_W       4
`define PRMD_POL_BIT     6
`define PRMD_RSV_BIT     7
`define PRMD_PHASE_LAST  6'h3F
`define PRMD_PERIOD_CYC  64
// -----------------------------------------------------------------
// register offsets (byte addresses) and reset values
// -----------------------------------------------------------------
`define PRMD_PW_BASE     12'h000
`define PRMD_FS_BASE     12'h040
`define PRMD_ST_OFS      12'h080
`define PRMD_PW_RST      8'h80
`define PRMD_FS_RST      8'h00
`define PRMD_PIN_LSB     16
`endif

/* File: logic/prmd_pkg.sv */
// types shared by the rate-multiplier pulse dac modules
package prmd_pkg;
  // per-channel state: un-inverted level and the registered pin
  typedef struct packed {
    logic level;
    logic pin;
  } prmd_chan_state_t;
endpackage

/* File: logic/prmd_chan_if.sv */
// link between the shared register/counter logic and one channel generator
`timescale 1ns/1ps
`include "prmd_defs.svh"
interface prmd_chan_if;
  logic [`PRMD_CNT_W-1:0] cnt;
  logic [`PRMD_PW_W-1:0]  weight;
  logic                   invert;
  logic [`PRMD_FS_W-1:0]  fine;
  logic                   pin;
  modport ctrl (output cnt, output weight, output invert, output fine, input pin);
  modport chan (input cnt, input weight, input invert, input fine, output pin);
endinterface

/* File: logic/prmd_channel.sv */
// one pulse-width / rate-multiplier output channel
`timescale 1ns/1ps
`include "prmd_defs.svh"
module prmd_channel (
  input  wire logic clk,
  input  wire logic sys_rst,
  prmd_chan_if.chan link
);
  prmd_pkg::prmd_chan_state_t st_q;
  prmd_pkg::prmd_chan_state_t st_d;
  logic [`PRMD_PW_W-1:0]      phase;
  logic [`PRMD_IDX_W-1:0]     next_idx;
  logic                       ext_set;

  // period selection by the fine-step nibble; period 0 never matches
  function automatic logic period_selected(input logic [3:0] idx, input logic [3:0] fs);
    period_selected = (fs[0] && idx == 4'h8) || (fs[1] && idx[2:0] == 3'h4) ||
                      (fs[2] && idx[1:0] == 2'h2) || (fs[3] && idx[0]);
  endfunction

  // -----------------------------------------------------------------
  // level generation
  // -----------------------------------------------------------------
  assign phase    = link.cnt[`PRMD_PW_W-1:0];
  assign next_idx = 4'(link.cnt[`PRMD_CNT_W-1:`PRMD_PW_W] + 4'h1);
  // the extra cycle sits just before the normal rise, so the pulse grows at its start
  assign ext_set  = (phase == `PRMD_PHASE_LAST) && period_selected(next_idx, link.fine);

  // set on the extra cycle beats the match reset of the previous pulse
  always_comb begin
    st_d = st_q;
    if (ext_set) begin
      st_d.level = 1'b1;
    end else if (phase == link.weight) begin
      st_d.level = 1'b0;
    end else if (phase == 6'h00) begin
      st_d.level = 1'b1;
    end
    st_d.pin = st_d.level ^ link.invert;
  end

  // pin flop resets low so the output is driven from the first moment
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign link.pin = st_q.pin;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  property p_wrap_set;
    @(posedge clk) disable iff (sys_rst)
      (phase == 6'h00 && link.weight != 6'h00) |=> st_q.level;
  endproperty
  a_wrap_set: assert property (p_wrap_set) else $error("level not set on wrap");

  property p_match_clr;
    @(posedge clk) disable iff (sys_rst)
      (phase == link.weight && !ext_set) |=> !st_q.level;
  endproperty
  a_match_clr: assert property (p_match_clr) else $error("level not cleared on match");

  property p_polarity;
    @(posedge clk) disable iff (sys_rst)
      ##1 (st_q.pin == (st_q.level ^ $past(link.invert)));
  endproperty
  a_polarity: assert property (p_polarity) else $error("pin polarity wrong");

  property p_widen;
    @(posedge clk) disable iff (sys_rst)
      (phase == 6'h3F && period_selected(next_idx, link.fine)) |=> st_q.level;
  endproperty
  a_widen: assert property (p_widen) else $error("extra cycle missing");

  property p_reset_low;
    @(posedge clk) sys_rst |-> !st_q.pin;
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("pin not low in reset");
endmodule

/* File: logic/prmd_top.sv */
// rate-multiplier pulse dac: shared counter, apb registers, channel generators
//
// Contract
// - one shared 10-bit counter steps every clock and wraps
// - when the low six counter bits wrap, active channel levels go high
// - six-bit phase equal to channel weight drives the level low
// - base period is 64 clocks, width resolution one clock
// - weight register bit 6 inverts the channel pin
// - selected periods gain one extra clock at the pulse start
// - fine-step bits select periods 8; 4,12; 2,6,10,14; odd; combined
// - weight zero and fine zero keep the level low
// - weight 3F, fine F: high except one clock around period 0
// - zero weight and fine with inversion give a steady high pin
// - channel pins are driven low from reset
// - weight register: bit 7 reads one, bits 5:0 weight, reset 80h
// - fine-step register: high nibble odd channel, low nibble even, reset 00h
// - channel count is a parameter; registers and pins scale with it; the address map and status word here hold 16 channels at most
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "prmd_defs.svh"
module prmd_top #(
  parameter int NCH = 2
) (
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  output logic      [NCH-1:0] pwm_out
);
  // -----------------------------------------------------------------
  // sizes and state
  // -----------------------------------------------------------------
  localparam int NFP = (NCH + 1) / 2;
  localparam logic ODD_LAST = (NCH % 2) == 1;

  // all flops of this module: counter, registers and the apb answer
  typedef struct packed {
    logic [`PRMD_CNT_W-1:0] cnt;
    logic [NCH-1:0][7:0]    weight;
    logic [NFP-1:0][7:0]    fine;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
  } prmd_top_state_t;

  prmd_top_state_t st_q;
  prmd_top_state_t st_d;

  logic [11:0]     pw_off;
  logic [11:0]     fs_off;
  logic            pw_hit;
  logic            fs_hit;
  logic            st_hit;
  logic [9:0]      pw_idx;
  logic [9:0]      fs_idx;
  logic            setup;
  logic            wr_en;
  logic [7:0]      fs_mask;
  logic [NCH-1:0]  pin_lvl;

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  // subtraction wraps below the base, so an address under it never hits
  assign pw_off = paddr - `PRMD_PW_BASE;
  assign fs_off = paddr - `PRMD_FS_BASE;
  assign pw_idx = pw_off[11:2];
  assign fs_idx = fs_off[11:2];

  // one aligned word per register; channel count sets the decoded span
  always_comb begin
    pw_hit = 1'b0;
    fs_hit = 1'b0;
    st_hit = 1'b0;
    if (pw_off[1:0] == 2'h0 && 32'(pw_idx) < NCH) begin
      pw_hit = 1'b1;
    end else if (fs_off[1:0] == 2'h0 && 32'(fs_idx) < NFP) begin
      fs_hit = 1'b1;
    end else if (paddr == `PRMD_ST_OFS) begin
      st_hit = 1'b1;
    end
  end

  // the last pair has no odd channel when the count is odd
  assign fs_mask = (ODD_LAST && 32'(fs_idx) == NFP - 1) ? 8'h0F : 8'hFF;

  assign setup = psel && !penable;
  // a write lands only at the edge where the access phase sees pready
  assign wr_en = psel && penable && st_q.pready && pwrite && pstrb[0];

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    st_d     = st_q;
    // free-running and never stopped; wrap is the natural 10-bit roll
    st_d.cnt = 10'(st_q.cnt + 10'h001);

    // answer is prepared in setup so the access phase lasts one cycle
    st_d.pready  = setup;
    st_d.pslverr = 1'b0;
    if (setup) begin
      st_d.prdata = 32'h0000_0000;
      if (pw_hit) begin
        st_d.prdata[7:0] = st_q.weight[pw_idx];
      end else if (fs_hit) begin
        st_d.prdata[7:0] = st_q.fine[fs_idx] & fs_mask;
      end else if (st_hit) begin
        st_d.prdata[`PRMD_CNT_W-1:0]  = st_q.cnt;
        st_d.prdata[`PRMD_PIN_LSB +: NCH] = pin_lvl;
      end else begin
        st_d.pslverr = 1'b1;
      end
    end

    // register writes; bit 7 of a weight is not storable and stays one
    if (wr_en && pw_hit) begin
      st_d.weight[pw_idx] = {1'b1, pwdata[6:0]};
    end else if (wr_en && fs_hit) begin
      st_d.fine[fs_idx] = pwdata[7:0] & fs_mask;
    end
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q.cnt     <= '0;
      st_q.weight  <= {NCH{`PRMD_PW_RST}};
      st_q.fine    <= {NFP{`PRMD_FS_RST}};
      st_q.prdata  <= 32'h0000_0000;
      st_q.pready  <= 1'b0;
      st_q.pslverr <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata  = st_q.prdata;
  assign pready  = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign pwm_out = pin_lvl;

  // -----------------------------------------------------------------
  // channel generators
  // -----------------------------------------------------------------
  // each channel sees the shared counter and its own slice of the registers
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    prmd_chan_if u_link ();
    assign u_link.cnt    = st_q.cnt;
    assign u_link.weight = st_q.weight[g][`PRMD_PW_W-1:0];
    assign u_link.invert = st_q.weight[g][`PRMD_POL_BIT];
    assign u_link.fine   = st_q.fine[g / 2][(g % 2) * 4 +: 4];
    assign pin_lvl[g]    = u_link.pin;

    prmd_channel u_chan (
      .clk     (clk),
      .sys_rst (sys_rst),
      .link    (u_link.chan)
    );

    // -----------------------------------------------------------------
    // per-channel checks
    // -----------------------------------------------------------------
    logic cfg_zero;
    logic cfg_full;
    assign cfg_zero = st_q.weight[g][6:0] == 7'h00 && u_link.fine == 4'h0;
    assign cfg_full = st_q.weight[g][6:0] == 7'h3F && u_link.fine == 4'hF;

    sequence s_zero_wrap;
      cfg_zero && st_q.cnt[5:0] == 6'h00;
    endsequence

    property p_zero_low;
      @(posedge clk) disable iff (sys_rst)
        s_zero_wrap ##1 cfg_zero |-> !pin_lvl[g];
    endproperty
    a_zero_low: assert property (p_zero_low) else $error("zero setting not low");

    sequence s_full_end;
      cfg_full && st_q.cnt == 10'h3FF;
    endsequence

    // the pin lags the counter by one clock, so the dip shows while the counter reads 000
    property p_full_dip;
      @(posedge clk) disable iff (sys_rst)
        s_full_end ##1 cfg_full |-> !pin_lvl[g] ##1 pin_lvl[g];
    endproperty
    a_full_dip: assert property (p_full_dip) else $error("full setting dip wrong");

    property p_full_high;
      @(posedge clk) disable iff (sys_rst)
        (cfg_full && st_q.cnt == 10'h3C0) ##1 cfg_full [*8] |-> pin_lvl[g];
    endproperty
    a_full_high: assert property (p_full_high) else $error("full setting not high");

    // zero weight and fine step with the invert bit set; cfg_zero also requires the invert bit clear
    logic cfg_blank;
    assign cfg_blank = st_q.weight[g][5:0] == 6'h00 && u_link.fine == 4'h0;

    sequence s_blank_inv_wrap;
      cfg_blank && st_q.weight[g][6] && st_q.cnt[5:0] == 6'h00;
    endsequence

    property p_static_high;
      @(posedge clk) disable iff (sys_rst)
        s_blank_inv_wrap ##1 (cfg_blank && st_q.weight[g][6]) |-> pin_lvl[g];
    endproperty
    a_static_high: assert property (p_static_high) else $error("static high lost");
  end

  // -----------------------------------------------------------------
  // shared checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // the edge that releases reset still resets the counter, so start only out of reset
  property p_cnt_step;
    !sys_rst |=> st_q.cnt == 10'($past(st_q.cnt) + 10'h001);
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter did not step");

  property p_period;
    (!sys_rst && st_q.cnt[5:0] == 6'h00) |-> ##64 (st_q.cnt[5:0] == 6'h00);
  endproperty
  a_period: assert property (p_period) else $error("period is not 64 clocks");

  property p_idx;
    (st_q.cnt[5:0] == 6'h3F) |=> st_q.cnt[9:6] == 4'($past(st_q.cnt[9:6]) + 4'h1);
  endproperty
  a_idx: assert property (p_idx) else $error("period index did not advance");

  sequence s_read_weight;
    setup && !pwrite && pw_hit;
  endsequence

  property p_weight_read;
    s_read_weight |=> pready && !pslverr && prdata[7];
  endproperty
  a_weight_read: assert property (p_weight_read) else $error("weight bit 7 not one");

  property p_weight_write;
    (wr_en && pw_hit && pw_idx == 10'h000) |=>
      st_q.weight[0] == {1'b1, $past(pwdata[6:0])};
  endproperty
  a_weight_write: assert property (p_weight_write) else $error("weight write lost");

  property p_fine_write;
    (wr_en && fs_hit && fs_idx == 10'h000) |=> st_q.fine[0][3:0] == $past(pwdata[3:0]);
  endproperty
  a_fine_write: assert property (p_fine_write) else $error("fine-step write lost");

  property p_answer;
    setup |=> pready ##1 !pready;
  endproperty
  a_answer: assert property (p_answer) else $error("apb answer not one cycle");

  property p_unmapped;
    (setup && !pw_hit && !fs_hit && !st_hit) |=> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");
endmodule

/* File: testbench/prmd_rc_filter.sv */
// behavioural rc load on one channel pin, integrating its high time
`timescale 1ns/1ps
module prmd_rc_filter (
  input  wire logic        clk,
  input  wire logic        clr,
  input  wire logic        ena,
  input  wire logic        pin,
  output logic      [10:0] charge
);
  // one charge step per high clock; a plain sum keeps the average exact,
  // traded against modelling the real exponential ripple
  always_ff @(posedge clk) begin
    if (clr) begin
      charge <= 11'h000;
    end else if (ena && pin) begin
      charge <= charge + 11'h001;
    end
  end
endmodule

/* File: testbench/test_pwm_rate_multiplier_dac.sv */
// self-checking bench for the rate-multiplier pulse dac
`timescale 1ns/1ps
`include "prmd_defs.svh"
module test_pwm_rate_multiplier_dac;
  localparam int NCH = 2;
  typedef struct { int ch; logic inv; logic [9:0] dac; } prmd_row_t;
  logic           clk = 1'b0;
  logic           sys_rst = 1'b0;
  logic           psel = 1'b0;
  logic           penable = 1'b0;
  logic           pwrite = 1'b0;
  logic [11:0]    paddr = 12'h000;
  logic [31:0]    pwdata = 32'h0;
  logic [3:0]     pstrb = 4'hF;
  logic [31:0]    prdata;
  logic           pready;
  logic           pslverr;
  logic [NCH-1:0] pwm_out;
  logic [9:0]     cnt_m;
  logic           win_ena = 1'b0;
  logic           win_clr = 1'b0;
  logic [10:0]    charge;
  int             sel_ch = 0;
  logic           sel_inv = 1'b0;
  int             hi [16];
  int             n_fail = 0;
  int             check_count = 0;
  logic [31:0]    rd;
  logic           er;
  logic [9:0]     c1;
  wire  [9:0]     cnt_sh = cnt_m + 10'h020;
  // rows hold one 10-bit conversion value: weight above, fine step below
  prmd_row_t rows [8] = '{'{0, 1'b0, 10'h186}, '{1, 1'b0, 10'h051}, '{0, 1'b0, 10'h032},
    '{1, 1'b0, 10'h078}, '{0, 1'b0, 10'h3FF}, '{1, 1'b1, 10'h000}, '{0, 1'b0, 10'h000},
    '{1, 1'b1, 10'h0A4}};

  prmd_top #(.NCH(NCH)) DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out));
  prmd_rc_filter u_load (.clk(clk), .clr(win_clr), .ena(win_ena), .pin(pwm_out[sel_ch]),
    .charge(charge));

  always #50 clk = ~clk;

  // mirror of the shared counter; windows straddle period starts by half a period
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) cnt_m <= 10'h000;
    else cnt_m <= cnt_m + 10'h001;
  end
  always @(posedge clk) begin
    if (win_clr) begin
      foreach (hi[k]) hi[k] <= 0;
    end else if (win_ena) begin
      hi[cnt_sh[9:6]] <= hi[cnt_sh[9:6]] + int'(pwm_out[sel_ch] ^ sel_inv);
    end
  end

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // odd periods, every 4th from 2, 4 and 12, and 8: disjoint sets, so a sum
  function automatic logic [31:0] sel_cnt(input logic [3:0] f, input int p);
    return (f[0] && p == 8) + (f[1] && p % 8 == 4) + (f[2] && p % 4 == 2) + (f[3] && p % 2 == 1);
  endfunction

  // one apb transfer; waits for pready without assuming a latency
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) check("apb answer", 0, 1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task complete_run;
    if (n_fail == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #4000000;
    n_fail++;
    complete_run();
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    // a real rising edge of reset clears the flops before the first clock edge
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    check("pins in reset", pwm_out, 0);
    sys_rst <= 1'b0;
    for (int c = 0; c < NCH; c++) begin
      apb(1'b0, `PRMD_PW_BASE + 12'(4 * c), 0, 4'hF);
      check("weight reset", rd, 32'h80);
    end
    apb(1'b0, `PRMD_FS_BASE, 0, 4'hF);
    check("fine reset", rd, 32'h0);
    check("pins idle", pwm_out, 0);
    foreach (rows[r]) begin
      sel_ch <= rows[r].ch;
      sel_inv <= rows[r].inv;
      apb(1'b1, `PRMD_PW_BASE + 12'(4 * rows[r].ch), {25'h0, rows[r].inv, rows[r].dac[9:4]},
          4'hF);
      apb(1'b1, `PRMD_FS_BASE, 32'(rows[r].dac[3:0]) << (4 * rows[r].ch), 4'hF);
      apb(1'b0, `PRMD_PW_BASE + 12'(4 * rows[r].ch), 0, 4'hF);
      check("weight readback", rd, {24'h0, 1'b1, rows[r].inv, rows[r].dac[9:4]});
      apb(1'b0, `PRMD_FS_BASE, 0, 4'hF);
      check("fine readback", rd, 32'(rows[r].dac[3:0]) << (4 * rows[r].ch));
      repeat (70) @(posedge clk);
      win_clr <= 1'b1;
      @(posedge clk);
      win_clr <= 1'b0;
      win_ena <= 1'b1;
      repeat (1024) @(posedge clk);
      win_ena <= 1'b0;
      @(posedge clk);
      check("high time", charge, rows[r].inv ? 11'h400 - rows[r].dac : rows[r].dac);
      // wide pulses reach past the window edge, so only narrow ones per period
      if (rows[r].dac[9:4] < 6'h19) begin
        for (int p = 0; p < 16; p++) begin
          check("period width", hi[p], rows[r].dac[9:4] + sel_cnt(rows[r].dac[3:0], p));
        end
      end
    end
    // counter steps once a clock: two status reads three clocks apart
    apb(1'b0, `PRMD_ST_OFS, 0, 4'hF);
    c1 = rd[9:0];
    apb(1'b0, `PRMD_ST_OFS, 0, 4'hF);
    check("counter step", 10'(rd[9:0] - c1), 3);
    apb(1'b0, 12'h0C0, 0, 4'hF);
    check("unmapped read err", er, 1);
    check("unmapped read data", rd, 0);
    apb(1'b1, 12'h0C0, 32'h55, 4'hF);
    check("unmapped write err", er, 1);
    apb(1'b1, `PRMD_PW_BASE, 32'h15, 4'h0);
    apb(1'b0, `PRMD_PW_BASE, 0, 4'hF);
    check("strobe-less write", rd, 32'h80);
    apb(1'b1, `PRMD_PW_BASE, 32'h40, 4'hF);
    repeat (100) @(posedge clk);
    check("static high", pwm_out[0], 1);
    apb(1'b0, `PRMD_ST_OFS, 0, 4'hF);
    check("status pin", rd[`PRMD_PIN_LSB], 1);
    sys_rst <= 1'b1;
    @(posedge clk);
    check("pins after reset", pwm_out, 0);
    sys_rst <= 1'b0;
    apb(1'b0, `PRMD_PW_BASE, 0, 4'hF);
    check("weight after reset", rd, 32'h80);
    complete_run();
  end
endmodule
